// ---- logic/sr_pkg.sv ----
package sr_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CONFIG_OFS   = 8'h00;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
  localparam logic [7:0] PHY_STAT_OFS = 8'h0c;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int RESET_REQ_BIT = 0;
  localparam int TO_BIT     = 1;
  localparam int SEL_BIT    = 2;
  localparam int STRAP_BIT  = 3;
  localparam int EV_DONE    = 0;
  localparam int EV_TIMEOUT = 1;
  localparam int EV_W       = 2;

  // ---------------------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  IRQ_MASK_RST = 2'h0;
  localparam int          CLK_HZ       = 40000000;
  localparam int          TIMEOUT_US   = 100;
  localparam int          TIMEOUT_CYC  = (CLK_HZ / 1000000) * TIMEOUT_US;
  localparam int          CLK_OK_CYC   = 8;
  localparam int          PULSE_CYC    = 4;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_PULSE = 4'b0100,
    ST_DONE  = 4'b1000
  } sr_state_t;

  typedef struct packed {
    logic        sel;
    logic [31:0] addr;
    logic        write;
    logic [2:0]  size;
  } ahb_req_t;

endpackage : sr_pkg

// ---- logic/clk_activity.sv ----
`timescale 1ns/1ps
`default_nettype none
// Flags a PHY clock as running when its divided toggle keeps changing.
module clk_activity
  import sr_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic tog_in,
  input  wire logic clear,
  output logic      running
);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        s3;
    logic [15:0] idle;
    logic        run;
  } ca_st_t;

  ca_st_t st_r;
  ca_st_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = tog_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (clear) begin
      st_nxt.idle = CNT_ZERO;
      st_nxt.run  = 1'b0;
    end else if (st_r.s3 != st_r.s2) begin
      st_nxt.idle = CNT_ZERO;
      st_nxt.run  = 1'b1;
    end else if (st_r.idle == 16'(CLK_OK_CYC)) begin
      st_nxt.run = 1'b0;
    end else begin
      st_nxt.idle = st_r.idle + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign running = st_r.run;

endmodule : clk_activity
`default_nettype wire

// ---- logic/sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic a;
    logic b;
  } s2_t;

  s2_t st_r;
  s2_t st_nxt;

  always_comb begin
    st_nxt   = st_r;
    st_nxt.a = d;
    st_nxt.b = st_r.a;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.b;

endmodule : sync2
`default_nettype wire

// ---- logic/soft_reset_and_phy_select.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Bit 3 reads the management data pin level captured at hard reset.
// - The captured strap is software information only, steering nothing.
// - Bit 2 selects the outside MII port when 1; resets to 0.
// - Bit 2 does not steer management port or clock multiplexing.
// - Soft reset without running PHY clocks times out and sets bit 1.
// - Writing 1 to bit 0 resets MAC and system registers, sparing immune bits.
// - Soft reset also clears pending transmit and receive error flags.
// - Bit 0 reads 0 after reset and clears itself when reset finishes.
// - Writes are ignored until one read follows reset or power-save return.
module soft_reset_and_phy_select
  import sr_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        mdio_pin,
  input  wire logic        phy_rx_clk_tog,
  input  wire logic        phy_tx_clk_tog,
  input  wire logic        power_save_exit,
  input  wire logic        transmit_error_evt,
  input  wire logic        receive_error_evt,
  output logic             transmit_error_flag,
  output logic             receive_error_flag,
  output logic             mac_regs_reset,
  output logic             sys_regs_reset,
  output logic             outside_mii_enable,
  output logic             internal_phy_enable,
  output logic             irq
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    ahb_req_t        req;
    logic [31:0]     rdata;
    logic [1:0]      strap_wait;
    logic            outside_transceiver_present_strap;
    logic            outside_transceiver_select;
    logic            sw_reset_timeout_flag;
    logic            write_unlocked;
    logic            tx_err;
    logic            rx_err;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    sr_state_t       fsm;
    logic [31:0]     cnt;
  } core_t;

  core_t st_r;
  core_t st_nxt;

  logic mdio_s;
  logic pse_s;
  logic rx_run;
  logic tx_run;
  logic restart;

  // Pin inputs pass two flops before anything reads them.
  sync2 u_mdio (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (mdio_pin),
    .q       (mdio_s)
  );

  sync2 u_pse (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (power_save_exit),
    .q       (pse_s)
  );

  clk_activity u_rx (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tog_in  (phy_rx_clk_tog),
    .clear   (restart),
    .running (rx_run)
  );

  clk_activity u_tx (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tog_in  (phy_tx_clk_tog),
    .clear   (restart),
    .running (tx_run)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  logic [EV_W-1:0] ev;
  logic            wr_hw;
  logic            wr_stat;
  logic            wr_mask;
  logic            rd_any;
  logic            soft_req;
  logic [31:0]     rd_val;

  always_comb begin
    st_nxt   = st_r;
    ev       = '0;
    wr_hw    = 1'b0;
    wr_stat  = 1'b0;
    wr_mask  = 1'b0;
    rd_any   = 1'b0;
    soft_req = 1'b0;
    rd_val   = 32'h0000_0000;

    // The synchroniser resets to 0, so the strap waits until it holds the pin level.
    if (st_r.strap_wait != 2'h3) begin
      st_nxt.strap_wait = st_r.strap_wait + 2'h1;
      if (st_r.strap_wait == 2'h2) begin
        st_nxt.outside_transceiver_present_strap = mdio_s;
      end
    end

    // Data phase of the previously accepted transfer.
    if (st_r.req.sel) begin
      if (st_r.req.write) begin
        if (st_r.write_unlocked) begin
          wr_hw   = (st_r.req.addr[7:0] == CONFIG_OFS);
          wr_stat = (st_r.req.addr[7:0] == IRQ_STAT_OFS);
          wr_mask = (st_r.req.addr[7:0] == IRQ_MASK_OFS);
        end
      end else begin
        rd_any = 1'b1;
      end
    end

    if (rd_any) begin
      st_nxt.write_unlocked = 1'b1;
    end
    if (pse_s) begin
      st_nxt.write_unlocked = 1'b0;
    end

    if (wr_hw) begin
      // Only the select bit steers the port enables.
      st_nxt.outside_transceiver_select = hwdata[SEL_BIT];
      soft_req                          = hwdata[RESET_REQ_BIT];
    end
    if (wr_mask) begin
      st_nxt.irq_mask = hwdata[EV_W-1:0];
    end

    // Soft reset sequencer.
    case (st_r.fsm)
      ST_IDLE: begin
        if (soft_req) begin
          st_nxt.fsm                   = ST_WAIT;
          st_nxt.cnt                   = 32'h0000_0000;
          st_nxt.sw_reset_timeout_flag = 1'b0;
        end
      end
      ST_WAIT: begin
        if (rx_run && tx_run) begin
          st_nxt.fsm = ST_PULSE;
          st_nxt.cnt = 32'h0000_0000;
        end else if (st_r.cnt == 32'(TIMEOUT_CYCLES - 1)) begin
          st_nxt.fsm                   = ST_IDLE;
          st_nxt.sw_reset_timeout_flag = 1'b1;
          ev[EV_TIMEOUT]               = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + 32'h0000_0001;
        end
      end
      ST_PULSE: begin
        if (st_r.cnt == 32'(PULSE_CYC - 1)) begin
          st_nxt.fsm = ST_DONE;
        end else begin
          st_nxt.cnt = st_r.cnt + 32'h0000_0001;
        end
      end
      ST_DONE: begin
        st_nxt.fsm    = ST_IDLE;
        ev[EV_DONE]   = 1'b1;
        st_nxt.irq_mask              = IRQ_MASK_RST;
        st_nxt.write_unlocked        = 1'b0;
      end
      default: begin
        st_nxt.fsm = ST_IDLE;
      end
    endcase

    // Error flags: new events win over the soft reset clear.
    if (st_r.fsm == ST_PULSE) begin
      st_nxt.tx_err = 1'b0;
      st_nxt.rx_err = 1'b0;
    end
    if (transmit_error_evt) begin
      st_nxt.tx_err = 1'b1;
    end
    if (receive_error_evt) begin
      st_nxt.rx_err = 1'b1;
    end

    // Sticky status, write one to clear, set wins.
    if (wr_stat) begin
      st_nxt.irq_stat = st_r.irq_stat & ~hwdata[EV_W-1:0];
    end
    st_nxt.irq_stat = st_nxt.irq_stat | ev;

    // Read mux, registered for the data phase.
    case (haddr[7:0])
      CONFIG_OFS: begin
        rd_val[STRAP_BIT] = st_r.outside_transceiver_present_strap;
        rd_val[SEL_BIT]   = st_r.outside_transceiver_select;
        rd_val[TO_BIT]    = st_r.sw_reset_timeout_flag;
        rd_val[RESET_REQ_BIT] = (st_r.fsm != ST_IDLE);
      end
      IRQ_STAT_OFS: rd_val[EV_W-1:0] = st_nxt.irq_stat;
      IRQ_MASK_OFS: rd_val[EV_W-1:0] = st_nxt.irq_mask;
      PHY_STAT_OFS: begin
        rd_val[0] = rx_run;
        rd_val[1] = tx_run;
      end
      default: rd_val = 32'h0000_0000;
    endcase

    // Address phase capture.
    st_nxt.req.sel = 1'b0;
    if (hready) begin
      st_nxt.req.sel   = hsel && htrans[1];
      st_nxt.req.addr  = haddr;
      st_nxt.req.write = hwrite;
      st_nxt.req.size  = hsize;
      if (hsel && htrans[1] && !hwrite) begin
        st_nxt.rdata = rd_val;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r          <= '0;
      st_r.fsm      <= ST_IDLE;
      st_r.irq_mask <= IRQ_MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign hrdata              = st_r.rdata;
  // A fresh soft reset clears the activity history so stale evidence is not used.
  assign restart             = soft_req;
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign mac_regs_reset      = (st_r.fsm == ST_PULSE);
  assign sys_regs_reset      = (st_r.fsm == ST_PULSE);
  assign transmit_error_flag = st_r.tx_err;
  assign receive_error_flag  = st_r.rx_err;
  assign outside_mii_enable  = st_r.outside_transceiver_select;
  assign internal_phy_enable = !st_r.outside_transceiver_select;
  assign irq                 = |(st_r.irq_stat & st_r.irq_mask);

endmodule : soft_reset_and_phy_select
`default_nettype wire

// ---- bench/sr_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module sr_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic transmit_error_evt,
  input wire logic receive_error_evt,
  input wire logic transmit_error_flag,
  input wire logic receive_error_flag,
  input wire logic mac_regs_reset,
  input wire logic sys_regs_reset,
  input wire logic outside_mii_enable,
  input wire logic internal_phy_enable
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence pulse_s;
    mac_regs_reset [*4] ##1 !mac_regs_reset;
  endsequence
  sequence quiet_s;
    (!transmit_error_evt && !receive_error_evt) [*4];
  endsequence
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");
  AST_SEL_INV: assert property (internal_phy_enable == !outside_mii_enable)
    else $error("phy enables not complementary");
  AST_RST_PAIR: assert property (mac_regs_reset == sys_regs_reset)
    else $error("mac and sys resets differ");
  AST_PULSE: assert property ($rose(mac_regs_reset) |-> pulse_s)
    else $error("soft reset pulse not four cycles");
  AST_SEL_KEEP: assert property (mac_regs_reset |=> $stable(outside_mii_enable))
    else $error("select bit moved during soft reset");
  AST_TX_SET: assert property (transmit_error_evt |=> transmit_error_flag)
    else $error("transmit error not flagged");
  AST_RX_SET: assert property (receive_error_evt |=> receive_error_flag)
    else $error("receive error not flagged");
  AST_ERR_CLR: assert property (($rose(mac_regs_reset) ##1 quiet_s) |->
    !transmit_error_flag && !receive_error_flag)
    else $error("error flags survive soft reset");
endmodule : sr_monitor
bind soft_reset_and_phy_select sr_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .transmit_error_evt(transmit_error_evt), .receive_error_evt(receive_error_evt),
  .transmit_error_flag(transmit_error_flag), .receive_error_flag(receive_error_flag),
  .mac_regs_reset(mac_regs_reset), .sys_regs_reset(sys_regs_reset),
  .outside_mii_enable(outside_mii_enable), .internal_phy_enable(internal_phy_enable));
`default_nettype wire

// ---- bench/ahb_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module ahb_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    // A read leaves write data flipping so a slave cannot lean on stale bits.
    hwdata <= w ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
endmodule : ahb_host
`default_nettype wire

// ---- bench/soft_reset_and_phy_select_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module soft_reset_and_phy_select_tb_top;
  import sr_pkg::*;
  localparam int TO_CYC = 20;
  logic        hclk, hresetn, hsel, hwrite, mdio_pin, rx_tog, tx_tog, phy_run;
  logic        ps_exit, tx_ev, rx_ev, hreadyout, hresp, txf, rxf, mac_rst, sys_rst;
  logic        omii, iphy, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          err_count, n_compared;

  soft_reset_and_phy_select #(.TIMEOUT_CYCLES(TO_CYC)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mdio_pin(mdio_pin),
    .phy_rx_clk_tog(rx_tog), .phy_tx_clk_tog(tx_tog), .power_save_exit(ps_exit),
    .transmit_error_evt(tx_ev), .receive_error_evt(rx_ev), .transmit_error_flag(txf),
    .receive_error_flag(rxf), .mac_regs_reset(mac_rst), .sys_regs_reset(sys_rst),
    .outside_mii_enable(omii), .internal_phy_enable(iphy), .irq(irq));
  ahb_host u_host (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Stopping phy_run freezes both toggles, which is how a sleeping PHY looks.
  always @(posedge hclk) begin
    rx_tog <= rx_tog ^ phy_run;
    tx_tog <= tx_tog ^ phy_run;
  end

  task wrap_up;
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    u_host.xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rd
  task wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask : wr
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task wait_pulse;
    int i;
    for (i = 0; i < 60 && mac_rst !== 1'b1; i++) @(negedge hclk);
    chk("sys_regs_reset", 32'h1, {31'h0, sys_rst});
    for (i = 0; i < 10 && mac_rst !== 1'b0; i++) @(negedge hclk);
    cyc(2);
  endtask : wait_pulse

  task s_lock;
    wr(CONFIG_OFS, 32'h4);
    rd(CONFIG_OFS, 32'h8, "config locked");
    rd(IRQ_MASK_OFS, 32'h0, "irq_mask reset");
    wr(8'h10, 32'hf);
    rd(8'h10, 32'h0, "unmapped");
    wr(CONFIG_OFS, 32'h4);
    rd(CONFIG_OFS, 32'hc, "config select");
    chk("mii enables", 32'h2, {30'h0, omii, iphy});
    rd(PHY_STAT_OFS, 32'h3, "phy_status");
    mdio_pin <= 1'b0;
    rd(CONFIG_OFS, 32'hc, "strap held");
  endtask : s_lock
  task s_soft;
    tx_ev <= 1'b1;
    rx_ev <= 1'b1;
    cyc(1);
    tx_ev <= 1'b0;
    rx_ev <= 1'b0;
    cyc(2);
    chk("error flags set", 32'h3, {30'h0, txf, rxf});
    wr(IRQ_MASK_OFS, 32'h3);
    wr(CONFIG_OFS, 32'h5);
    wait_pulse;
    chk("error flags", 32'h0, {30'h0, txf, rxf});
    rd(CONFIG_OFS, 32'hc, "config done");
    rd(IRQ_MASK_OFS, 32'h0, "mask after sw_reset_request");
    rd(IRQ_STAT_OFS, 32'h1, "status done");
    wr(IRQ_MASK_OFS, 32'h1);
    cyc(2);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(IRQ_MASK_OFS, 32'h0);
    cyc(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(IRQ_MASK_OFS, 32'h1);
    wr(IRQ_STAT_OFS, 32'h1);
    cyc(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(IRQ_STAT_OFS, 32'h0, "status cleared");
  endtask : s_soft
  task s_timeout;
    phy_run <= 1'b0;
    cyc(12);
    rd(PHY_STAT_OFS, 32'h0, "phy stopped");
    wr(CONFIG_OFS, 32'h5);
    cyc(TO_CYC + 10);
    chk("no reset pulse", 32'h0, {31'h0, mac_rst});
    rd(CONFIG_OFS, 32'he, "config timeout");
    rd(IRQ_STAT_OFS, 32'h2, "status timeout");
    phy_run <= 1'b1;
    cyc(12);
    wr(CONFIG_OFS, 32'h5);
    wait_pulse;
    rd(CONFIG_OFS, 32'hc, "config retry");
  endtask : s_timeout
  task s_psave;
    ps_exit <= 1'b1;
    cyc(3);
    ps_exit <= 1'b0;
    cyc(4);
    wr(IRQ_MASK_OFS, 32'h2);
    rd(IRQ_MASK_OFS, 32'h0, "mask relocked");
    wr(IRQ_MASK_OFS, 32'h2);
    rd(IRQ_MASK_OFS, 32'h2, "mask unlocked");
  endtask : s_psave
  task s_strap_low;
    hresetn <= 1'b0;
    cyc(3);
    hresetn <= 1'b1;
    cyc(4);
    rd(CONFIG_OFS, 32'h0, "strap low");
  endtask : s_strap_low

  initial begin
    {hresetn, rx_tog, tx_tog, ps_exit, tx_ev, rx_ev} = '0;
    mdio_pin   = 1'b1;
    phy_run    = 1'b1;
    err_count  = 0;
    n_compared = 0;
    cyc(12);
    hresetn <= 1'b1;
    cyc(2);
    s_lock;
    s_soft;
    s_timeout;
    s_psave;
    s_strap_low;
    wrap_up;
  end
  initial begin
    #500000;
    err_count++;
    wrap_up;
  end
endmodule : soft_reset_and_phy_select_tb_top
`default_nettype wire
